/* common/uasu_pkg.sv */
// package of the async serial unit status and data buffer block
// assumes one bus clock; shifter and sampler logic live outside this block
package uasu_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS1 = 8'h10;
  localparam logic [7:0] ADDR_STATUS2 = 8'h14;
  localparam logic [7:0] ADDR_DATA    = 8'h18;
  localparam logic [7:0] ADDR_ERRCTL  = 8'h1C;
  // control register fields
  localparam int CTRL_TXE_IE  = 7;
  localparam int CTRL_TC_IE   = 6;
  localparam int CTRL_RXF_IE  = 5;
  localparam int CTRL_IDLE_IE = 4;
  localparam int CTRL_RX_EN   = 3;
  localparam int CTRL_MODE9   = 0;
  // error control register fields
  localparam int ERR_NINTH    = 7;
  localparam int ERR_OVR_IE   = 3;
  localparam int ERR_NOISE_IE = 2;
  localparam int ERR_FRAME_IE = 1;
  localparam int ERR_PAR_IE   = 0;
  // secondary status fields
  localparam int ST2_BREAK    = 1;
  localparam int ST2_RPF      = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [3:0] ERR_EN_RESET = 4'h0;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  // flag order equals the primary status byte, bit 7 first
  typedef struct packed {
    logic tx_empty;
    logic tx_complete;
    logic rx_full;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } uasu_flags_t;

  localparam uasu_flags_t FLAGS_RESET = 8'hC0;

  typedef struct packed {
    logic       char_done;
    logic       break_det;
    logic       noise;
    logic       parity_err;
    logic       stop_zero;
    logic       start_low;
    logic       false_start;
    logic       idle_char;
    logic [8:0] data;
  } uasu_rx_evt_t;

  typedef struct packed {
    logic load;
    logic active;
    logic queued;
  } uasu_tx_evt_t;

  typedef struct packed {
    uasu_flags_t flags;
    logic        brk;
    logic        rx_in_progress_flag;
    uasu_flags_t arm1;
    logic        arm2;
    logic [7:0]  ctrl;
    logic [3:0]  err_en;
    logic        idle_allow;
    logic        brk_rearm;
    logic [1:0]  pin_sync;
    logic        ph_sel;
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic [7:0]  rdata;
  } uasu_state_t;

  typedef struct packed {
    logic [7:0] rx_data;
    logic       rx_ninth;
    logic [7:0] tx_data;
  } uasu_buf_t;
endpackage

/* core/uasu_top.sv */
// status flags, interrupt requests and data buffer of the async serial unit
// assumes the receive sampler and transmit shifter run on SYS_CLK and give one-cycle events
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module uasu_top
  import uasu_pkg::*;
(
  input  wire logic          SYS_CLK,
  input  wire logic          RESET,
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic          HREADY,
  input  wire logic [31:0]   HWDATA,
  output logic      [31:0]   HRDATA,
  output logic               HREADYOUT,
  output logic               HRESP,
  input  wire logic          RX_INPUT_PIN,
  input  wire uasu_rx_evt_t  RX_EVT,
  input  wire uasu_tx_evt_t  TX_EVT,
  output logic      [7:0]    TX_DATA,
  output logic               TX_IRQ,
  output logic               RX_IRQ,
  output logic               ERR_IRQ,
  output logic               RX_ENABLE,
  output logic               MODE9
);
  uasu_state_t s;
  uasu_state_t next_s;
  uasu_buf_t   b;
  uasu_buf_t   next_b;
  logic        addr_phase;
  logic        wr_hit;
  logic        rd_s1;
  logic        rd_s2;
  logic        rd_data;
  logic        wr_data;
  logic        rx_accept;
  logic        line_high;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // reads act in the address phase so the returned byte and the arming agree
  assign addr_phase = HSEL && HTRANS[1] && HREADY;
  assign rd_s1      = addr_phase && !HWRITE && hit(HADDR[7:0], ADDR_STATUS1);
  assign rd_s2      = addr_phase && !HWRITE && hit(HADDR[7:0], ADDR_STATUS2);
  assign rd_data    = addr_phase && !HWRITE && hit(HADDR[7:0], ADDR_DATA);
  assign wr_hit     = s.ph_sel && s.ph_write;
  assign wr_data    = wr_hit && hit(s.ph_addr, ADDR_DATA);
  assign rx_accept  = RX_EVT.char_done && !s.flags.rx_full;
  assign line_high  = s.pin_sync[1];

  always_comb begin
    next_s = s;
    next_b = b;
    next_s.pin_sync = {s.pin_sync[0], RX_INPUT_PIN};
    // data phase writes
    if (wr_hit && hit(s.ph_addr, ADDR_CTRL)) begin
      next_s.ctrl = HWDATA[7:0];
      // enabling the receiver demands a fresh character
      if (HWDATA[CTRL_RX_EN] && !s.ctrl[CTRL_RX_EN]) begin
        next_s.idle_allow = 1'b0;
      end
    end
    if (wr_hit && hit(s.ph_addr, ADDR_ERRCTL)) begin
      next_s.err_en = HWDATA[3:0];
    end
    if (wr_data) begin
      next_b.tx_data = HWDATA[7:0];
      if (s.arm1.tx_empty) begin
        next_s.flags.tx_empty = 1'b0;
        next_s.arm1.tx_empty  = 1'b0;
      end
    end
    // data read clears only the flags that the status read saw set
    if (rd_data) begin
      next_s.flags.rx_full = s.flags.rx_full & ~s.arm1.rx_full;
      next_s.flags.idle    = s.flags.idle & ~s.arm1.idle;
      next_s.flags.overrun = s.flags.overrun & ~s.arm1.overrun;
      next_s.flags.noise   = s.flags.noise & ~s.arm1.noise;
      next_s.flags.framing = s.flags.framing & ~s.arm1.framing;
      next_s.flags.parity  = s.flags.parity & ~s.arm1.parity;
      if (s.arm1.idle) begin
        next_s.idle_allow = 1'b0;
      end
      if (s.arm2) begin
        next_s.brk = 1'b0;
      end
      next_s.arm1 = '0;
      next_s.arm1.tx_empty = s.arm1.tx_empty;
      next_s.arm2 = 1'b0;
    end
    // logic 1s on the line rearm break detection
    if (line_high) begin
      next_s.brk_rearm = 1'b1;
    end
    // hardware sets follow the clears so a set in the same cycle wins
    // shifter took the character
    if (TX_EVT.load) begin
      next_s.flags.tx_empty = 1'b1;
    end
    if (RX_EVT.char_done) begin
      if (rx_accept) begin
        next_s.flags.rx_full = 1'b1;
        next_s.idle_allow    = 1'b1;
        next_b.rx_data       = RX_EVT.data[7:0];
        next_b.rx_ninth      = s.ctrl[CTRL_MODE9] ? RX_EVT.data[8] : RX_EVT.data[7];
        if (RX_EVT.break_det && s.ctrl[CTRL_MODE9]) begin
          next_b.rx_ninth = 1'b0;
        end
      end else begin
        next_s.flags.overrun = 1'b1;
      end
      if (RX_EVT.stop_zero || RX_EVT.break_det) begin
        next_s.flags.framing = 1'b1;
      end
      if (RX_EVT.parity_err) begin
        next_s.flags.parity = 1'b1;
      end
      if (RX_EVT.break_det && s.brk_rearm) begin
        next_s.brk       = 1'b1;
        next_s.brk_rearm = 1'b0;
      end
      next_s.rx_in_progress_flag = 1'b0;
    end
    if (RX_EVT.noise) begin
      next_s.flags.noise = 1'b1;
    end
    // idle gated by a prior valid character
    if (RX_EVT.idle_char && s.idle_allow) begin
      next_s.flags.idle = 1'b1;
    end
    if (RX_EVT.false_start || RX_EVT.idle_char) begin
      next_s.rx_in_progress_flag = 1'b0;
    end
    if (RX_EVT.start_low) begin
      next_s.rx_in_progress_flag = 1'b1;
    end
    // tx complete follows empty and idle shifter, queueing clears it
    next_s.flags.tx_complete = next_s.flags.tx_empty && !TX_EVT.active && !TX_EVT.queued;
    // address phase capture and read data from the updated state
    next_s.ph_sel   = addr_phase;
    next_s.ph_write = HWRITE;
    next_s.ph_addr  = HADDR[7:0];
    next_s.rdata    = 8'h00;
    if (addr_phase && !HWRITE) begin
      case (HADDR[7:0])
        ADDR_CTRL:    next_s.rdata = next_s.ctrl;
        ADDR_STATUS1: next_s.rdata = next_s.flags;
        ADDR_STATUS2: begin
          next_s.rdata[ST2_BREAK] = next_s.brk;
          next_s.rdata[ST2_RPF]   = next_s.rx_in_progress_flag;
        end
        ADDR_DATA:    next_s.rdata = next_b.rx_data;
        ADDR_ERRCTL:  next_s.rdata = {next_b.rx_ninth, 3'h0, next_s.err_en};
        default:      next_s.rdata = 8'h00;
      endcase
    end
    // arming records what software saw; it holds until the data access
    if (rd_s1) begin
      next_s.arm1 = next_s.arm1 | next_s.flags;
    end
    if (rd_s2 && next_s.brk) begin
      next_s.arm2 = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s            <= '0;
      s.flags      <= FLAGS_RESET;
      s.ctrl       <= CTRL_RESET;
      s.err_en     <= ERR_EN_RESET;
      s.brk_rearm  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // the data buffer has no reset: its contents survive a system reset
  always_ff @(posedge SYS_CLK) begin
    b <= next_b;
  end

  assign HRDATA    = {24'h000000, s.rdata};
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign TX_DATA   = b.tx_data;
  assign RX_ENABLE = s.ctrl[CTRL_RX_EN];
  assign MODE9     = s.ctrl[CTRL_MODE9];
  assign TX_IRQ = (s.flags.tx_empty && s.ctrl[CTRL_TXE_IE])
               || (s.flags.tx_complete && s.ctrl[CTRL_TC_IE]);
  // receiver request; break and in-progress never request
  assign RX_IRQ = (s.flags.rx_full && s.ctrl[CTRL_RXF_IE])
               || (s.flags.idle && s.ctrl[CTRL_IDLE_IE]);
  assign ERR_IRQ = (s.flags.overrun && s.err_en[ERR_OVR_IE])
                || (s.flags.noise && s.err_en[ERR_NOISE_IE])
                || (s.flags.framing && s.err_en[ERR_FRAME_IE])
                || (s.flags.parity && s.err_en[ERR_PAR_IE]);

  sequence s_status_seen_rx;
    rd_s1 && s.flags.rx_full;
  endsequence
  sequence s_data_read_quiet;
    rd_data && !RX_EVT.char_done;
  endsequence

  property p_noise_irq;
    @(posedge SYS_CLK) disable iff (RESET)
    (s.flags.noise && s.err_en[ERR_NOISE_IE]) |-> ERR_IRQ;
  endproperty
  a_noise_irq: assert property (p_noise_irq) else $error("noise request missing");

  property p_err_quiet;
    @(posedge SYS_CLK) disable iff (RESET)
    (((s.flags & 8'h0F) & {4'h0, s.err_en}) == 8'h00) |-> !ERR_IRQ;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error request without source");

  property p_frame_irq;
    @(posedge SYS_CLK) disable iff (RESET)
    (RX_EVT.char_done && RX_EVT.stop_zero && s.err_en[ERR_FRAME_IE]) |=> ERR_IRQ;
  endproperty
  a_frame_irq: assert property (p_frame_irq) else $error("framing request missing");

  property p_tx_load;
    @(posedge SYS_CLK) disable iff (RESET)
    TX_EVT.load |=> s.flags.tx_empty;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx empty not set on load");

  property p_tx_clear;
    @(posedge SYS_CLK) disable iff (RESET)
    $fell(s.flags.tx_empty) |-> $past(wr_data && s.arm1.tx_empty);
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx empty cleared without sequence");

  property p_tc_queue;
    @(posedge SYS_CLK) disable iff (RESET)
    TX_EVT.queued |=> !s.flags.tx_complete;
  endproperty
  a_tc_queue: assert property (p_tc_queue) else $error("tx complete kept after queueing");

  property p_tc_empty;
    @(posedge SYS_CLK) disable iff (RESET)
    s.flags.tx_complete |-> s.flags.tx_empty;
  endproperty
  a_tc_empty: assert property (p_tc_empty) else $error("tx complete without tx empty");

  property p_rx_clear;
    @(posedge SYS_CLK) disable iff (RESET)
    s_status_seen_rx ##2 s_data_read_quiet |=> !s.flags.rx_full;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx full not cleared");

  property p_overrun;
    @(posedge SYS_CLK) disable iff (RESET)
    (RX_EVT.char_done && s.flags.rx_full) |=> s.flags.overrun && $stable(b.rx_data);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");

  property p_ovr_clear;
    @(posedge SYS_CLK) disable iff (RESET)
    $fell(s.flags.overrun) |-> $past(rd_data && s.arm1.overrun);
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun cleared unarmed");

  property p_break;
    @(posedge SYS_CLK) disable iff (RESET)
    (RX_EVT.char_done && RX_EVT.break_det && s.brk_rearm)
      |=> s.brk && s.flags.framing && s.flags.rx_full;
  endproperty
  a_break: assert property (p_break) else $error("break flags not set");

  property p_rpf;
    @(posedge SYS_CLK) disable iff (RESET)
    RX_EVT.start_low |=> s.rx_in_progress_flag;
  endproperty
  a_rpf: assert property (p_rpf) else $error("in-progress not set");
endmodule
`default_nettype wire

/* bench/uasu_peer.sv */
// stand-in for the remote node, receive sampler and transmit shifter
// assumes its tasks are entered just after a rising SYS_CLK edge
`timescale 1ns/1ns
`default_nettype none
module uasu_peer
  import uasu_pkg::*;
(
  input  wire logic    SYS_CLK,
  input  wire logic [7:0] TX_DATA,
  output var logic     RX_INPUT_PIN,
  output var uasu_rx_evt_t RX_EVT,
  output var uasu_tx_evt_t TX_EVT
);
  logic [7:0] tx_taken;
  initial begin
    RX_INPUT_PIN = 1'b1;
    RX_EVT = '0;
    TX_EVT = '0;
    tx_taken = 8'h00;
  end
  // one-cycle receive event
  // data shows its inverse afterwards so a stale byte never looks valid
  task automatic pulse(input uasu_rx_evt_t e);
    RX_EVT <= e;
    @(posedge SYS_CLK);
    RX_EVT <= {8'h00, ~e.data};
    @(posedge SYS_CLK);
  endtask
  task automatic take();
    TX_EVT <= 3'b110;
    @(posedge SYS_CLK);
    tx_taken = TX_DATA;
    TX_EVT.load <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic hold(input logic act, input logic que);
    TX_EVT <= {1'b0, act, que};
    repeat (2) @(posedge SYS_CLK);
  endtask
  // three edges cover the two-flop synchroniser
  task automatic pin(input logic lvl);
    RX_INPUT_PIN <= lvl;
    repeat (3) @(posedge SYS_CLK);
  endtask
endmodule
`default_nettype wire

/* bench/tb_uasu_top.sv */
// self-checking bench of the async serial unit flags and data buffer
// assumes one AHB-Lite master; the slave's own hreadyout closes each phase
`timescale 1ns/1ns
`default_nettype none
module tb_uasu_top
  import uasu_pkg::*;
;
  logic         sys_clk;
  logic         reset;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic         rx_pin;
  uasu_rx_evt_t rx_evt;
  uasu_tx_evt_t tx_evt;
  logic [7:0]   tx_data;
  logic         tx_irq;
  logic         rx_irq;
  logic         err_irq;
  logic         rx_enable;
  logic         mode9;
  logic [31:0]  v;
  int           error_cnt = 0;
  int           total_checks = 0;
  logic [7:0]   err_kind [4] = '{8'h90, 8'h88, 8'h20, 8'h80};
  logic [7:0]   rpf_kind [4] = '{8'h04, 8'h02, 8'h04, 8'h01};

  uasu_top i_dut (.SYS_CLK(sys_clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout),
    .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .RX_INPUT_PIN(rx_pin), .RX_EVT(rx_evt), .TX_EVT(tx_evt), .TX_DATA(tx_data),
    .TX_IRQ(tx_irq), .RX_IRQ(rx_irq), .ERR_IRQ(err_irq), .RX_ENABLE(rx_enable),
    .MODE9(mode9));
  uasu_peer i_peer (.SYS_CLK(sys_clk), .TX_DATA(tx_data), .RX_INPUT_PIN(rx_pin),
    .RX_EVT(rx_evt), .TX_EVT(tx_evt));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ_BIT;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    v = hrdata;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // the data buffer is only ever written whole, never read-modify-written
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    rd(a);
    chk(n, v, {24'h0, e});
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rc(ADDR_STATUS1, 8'hC0, "status1");
    rc(ADDR_STATUS2, 8'h00, "status2");
    rc(ADDR_CTRL, 8'h00, "ctrl");
    rd(ADDR_ERRCTL);
    chk("error enables", v[3:0], 32'h0);
    rc(8'h20, 8'h00, "unmapped");
    chk("irqs", {hresp, tx_irq, rx_irq, err_irq}, 32'h0);
    done("reset");
    wr(ADDR_CTRL, 8'h80);
    rc(ADDR_CTRL, 8'h80, "ctrl");
    chk("tx irq", tx_irq, 32'h1);
    wr(ADDR_CTRL, 8'h40);
    rc(ADDR_CTRL, 8'h40, "ctrl");
    chk("tc irq", tx_irq, 32'h1);
    // the reset-time status read armed tx empty, so this write clears it
    wr(ADDR_DATA, 8'h5A);
    rc(ADDR_STATUS1, 8'h00, "status1");
    i_peer.take();
    chk("taken", i_peer.tx_taken, 32'h5A);
    // no status read saw the new tx empty, so this write must keep it
    wr(ADDR_DATA, 8'hA5);
    rc(ADDR_CTRL, 8'h40, "ctrl");
    chk("tx data", tx_data, 32'hA5);
    rc(ADDR_STATUS1, 8'h80, "status1");
    i_peer.hold(1'b1, 1'b1);
    i_peer.hold(1'b0, 1'b1);
    rc(ADDR_STATUS1, 8'h80, "status1");
    i_peer.hold(1'b0, 1'b0);
    rc(ADDR_STATUS1, 8'hC0, "status1");
    chk("tc irq", tx_irq, 32'h1);
    done("transmit");
    wr(ADDR_CTRL, 8'h28);
    i_peer.pulse({8'h80, 9'h03C});
    chk("rx irq", {rx_enable, rx_irq}, 32'h3);
    rc(ADDR_STATUS1, 8'hE0, "status1");
    i_peer.pulse({8'h80, 9'h0C3});
    rc(ADDR_DATA, 8'h3C, "rx data");
    // second status read catches the overrun that slipped in
    rc(ADDR_STATUS1, 8'hC8, "status1");
    rc(ADDR_DATA, 8'h3C, "rx data");
    rc(ADDR_STATUS1, 8'hC0, "status1");
    done("overrun");
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_ERRCTL, 8'h00);
      if (b == 3) begin
        i_peer.pulse({8'h80, 9'h011});
      end
      i_peer.pulse({err_kind[b], 9'h022});
      rd(ADDR_STATUS1);
      chk("error flag", v[b], 32'h1);
      chk("error irq", err_irq, 32'h0);
      wr(ADDR_ERRCTL, 8'(1 << b));
      rd(ADDR_ERRCTL);
      chk("error irq", err_irq, 32'h1);
      rd(ADDR_DATA);
      rd(ADDR_STATUS1);
      chk("error flag", v[b], 32'h0);
      chk("error irq", err_irq, 32'h0);
    end
    done("errors");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h19);
    i_peer.pulse({8'h01, 9'h0});
    rc(ADDR_STATUS1, 8'hC0, "status1");
    i_peer.pulse({8'h80, 9'h1A5});
    rd(ADDR_ERRCTL);
    chk("ninth bit", {mode9, v[7]}, 32'h3);
    rd(ADDR_STATUS1);
    rc(ADDR_DATA, 8'hA5, "rx data");
    i_peer.pulse({8'h01, 9'h0});
    chk("idle irq", rx_irq, 32'h1);
    rc(ADDR_STATUS1, 8'hD0, "status1");
    rd(ADDR_DATA);
    i_peer.pulse({8'h01, 9'h0});
    rc(ADDR_STATUS1, 8'hC0, "status1");
    done("idle");
    for (int i = 0; i < 4; i++) begin
      i_peer.pulse({rpf_kind[i], 9'h0});
      rc(ADDR_STATUS2, 8'(~i & 1), "status2");
    end
    done("in progress");
    i_peer.pin(1'b0);
    i_peer.pulse({8'hC8, 9'h100});
    rc(ADDR_STATUS2, 8'h02, "status2");
    rc(ADDR_STATUS1, 8'hE2, "status1");
    rd(ADDR_ERRCTL);
    chk("ninth bit", v[7], 32'h0);
    rd(ADDR_DATA);
    rc(ADDR_STATUS2, 8'h00, "status2");
    i_peer.pulse({8'hC8, 9'h0});
    rc(ADDR_STATUS2, 8'h00, "status2");
    rd(ADDR_STATUS1);
    rd(ADDR_DATA);
    i_peer.pin(1'b1);
    i_peer.pin(1'b0);
    wr(ADDR_ERRCTL, 8'h02);
    i_peer.pulse({8'hC8, 9'h0});
    rc(ADDR_STATUS2, 8'h02, "status2");
    chk("framing irq", err_irq, 32'h1);
    done("break");
    rd(ADDR_STATUS1);
    rd(ADDR_DATA);
    i_peer.pulse({8'h80, 9'h0C6});
    // a mid-run reset must leave both halves of the data buffer alone
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rc(ADDR_STATUS1, 8'hC0, "status1");
    rc(ADDR_DATA, 8'hC6, "rx data");
    chk("tx data", tx_data, 32'hA5);
    done("reset again");
    end_of_test();
  end
endmodule
`default_nettype wire
